/* File: gpe_defs.vh */
// Register offsets, reset values and field positions of the port block
`ifndef GPE_DEFS_VH
`define GPE_DEFS_VH
`define GPE_OFS_DIR 12'h400
`define GPE_OFS_IS 12'h404
`define GPE_OFS_IBE 12'h408
`define GPE_OFS_IEV 12'h40C
`define GPE_OFS_IM 12'h410
`define GPE_OFS_RIS 12'h414
`define GPE_OFS_MIS 12'h418
`define GPE_OFS_ICR 12'h41C
`define GPE_OFS_AFSEL 12'h420
`define GPE_OFS_DR2R 12'h500
`define GPE_OFS_DR4R 12'h504
`define GPE_OFS_DR8R 12'h508
`define GPE_OFS_ODR 12'h50C
`define GPE_OFS_PUR 12'h510
`define GPE_OFS_PDR 12'h514
`define GPE_OFS_SLR 12'h518
`define GPE_OFS_DEN 12'h51C
`define GPE_OFS_ID_FIRST 12'hFD0
`define GPE_DATA_SEL_MSB 11
`define GPE_DATA_SEL_LSB 10
`define GPE_MASK_MSB 9
`define GPE_MASK_LSB 2
`define GPE_ID_IDX_MSB 5
`define GPE_ID_IDX_LSB 2
`define GPE_ID_IDX_BASE 4'h4
`define GPE_ID_WORDS 12
`define GPE_RST_ZERO 8'h00
`define GPE_RST_DR2R 8'hFF
`define GPE_RST_PUR 8'hFF
`define GPE_RST_DEN 8'hFF
`define GPE_PORT_B 3'h1
`define GPE_PORT_C 3'h2
`define GPE_RST_AFSEL_B 8'h80
`define GPE_RST_AFSEL_C 8'h0F
`define GPE_TRST_PIN 15
`endif

/* File: gpe_pin_model.sv */
// Pad-side model: external drivers, pulls and floating pins
module gpe_pin_model (
  input wire clk, // System clock
  input wire [39:0] pin_out, // Design levels
  input wire [39:0] pin_oe, // Design enables
  input wire [39:0] pull_up, // Pull-ups
  input wire [39:0] pull_down, // Pull-downs
  input wire [39:0] ext_val, // External levels
  input wire [39:0] ext_oe, // External enables
  output logic [39:0] pin_level // Resolved levels
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [39:0] last_reg = 40'h0;
  wire [39:0] held = pin_oe | ext_oe | pull_up | pull_down;
  // A floating pin shows the inverse of its last driven level, so stale data never passes for a match
  always_comb begin
    for (int i = 0; i < 40; i++)
      pin_level[i] = pin_oe[i] ? pin_out[i] : ext_oe[i] ? ext_val[i] : pull_up[i] | (~pull_down[i] & ~last_reg[i]);
  end
  always @(posedge clk) last_reg <= (pin_level & held) | (last_reg & ~held);
endmodule // gpe_pin_model

/* File: gpe_sync.v */
// Two-flop synchroniser for a vector of pin levels
module gpe_sync #(
  parameter W = 8
) (
  input wire CLK, // System clock
  input wire RST_N, // Asynchronous reset, active low
  input wire [W-1:0] D, // Asynchronous levels
  output wire [W-1:0] Q // Synchronised levels
);
  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
    end else begin
      meta_reg <= D;
      sync_reg <= meta_reg;
    end
  end

  assign Q = sync_reg;
endmodule // gpe_sync

/* File: gpe_top.v */
// Five eight-pin I/O ports, differing only in AFSEL reset value, with masked data window and pin interrupts
`include "gpe_defs.vh"

module gpe_top #(
  parameter NP = 5, // Number of ports
  parameter [95:0] IDENT_WORDS = 96'h0C0B0A09_08070605_04030201 // Arbitrary identification values
) (
  input wire CLK, // System clock
  input wire RST_N, // Power-on or external reset, active low
  input wire [NP-1:0] CLK_GATE, // Per-port clock-gating enable
  input wire [2:0] ACC_PORT, // Port selected for an access
  input wire [11:0] ACC_ADDR, // Byte offset within the port
  input wire ACC_WR, // Write strobe
  input wire ACC_RD, // Read strobe
  input wire [7:0] ACC_WDATA, // Write data
  output reg [7:0] ACC_RDATA, // Read data, valid with ACC_RVALID
  output reg ACC_RVALID, // Read answer pulse
  input wire [NP*8-1:0] PIN_IN, // Pad input levels
  output wire [NP*8-1:0] PIN_OUT, // Pad output levels
  output wire [NP*8-1:0] PIN_OE, // Pad output enables, high drives
  output wire [NP*8-1:0] ALT_IN, // Synchronised levels to peripherals
  input wire [NP*8-1:0] ALT_OUT, // Peripheral output levels
  input wire [NP*8-1:0] ALT_OE, // Peripheral output enables
  output wire [NP*8-1:0] PAD_DRV2, // Low drive select
  output wire [NP*8-1:0] PAD_DRV4, // Mid drive select
  output wire [NP*8-1:0] PAD_DRV8, // High drive select
  output wire [NP*8-1:0] PAD_ODR, // Open-drain select
  output wire [NP*8-1:0] PAD_PU, // Pull-up select
  output wire [NP*8-1:0] PAD_PD, // Pull-down select
  output wire [NP*8-1:0] PAD_SLEW, // Slew-rate control select
  output wire [NP*8-1:0] PAD_DEN, // Digital pad enable
  output wire [NP-1:0] IRQ, // Per-port interrupt, active high
  output wire TEST_RST_N // Test logic reset, active low
);
  localparam W = 8;

  wire [NP*W-1:0] rd_all;
  wire [NP*W-1:0] afsel_all;
  wire [W-1:0] addr_mask = ACC_ADDR[`GPE_MASK_MSB:`GPE_MASK_LSB];
  wire in_data_win = (ACC_ADDR[`GPE_DATA_SEL_MSB:`GPE_DATA_SEL_LSB] == 2'h0);
  wire in_id_win = (ACC_ADDR >= `GPE_OFS_ID_FIRST) && (ACC_ADDR[1:0] == 2'h0);
  reg [W-1:0] rd_merge;
  integer k;
  reg [1:0] settle_reg;
  wire edge_armed = (settle_reg == 2'h3);

  // Synchronisers leave reset at zero, so the first transitions after reset are not real pin events
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      settle_reg <= 2'h0;
    end else if (settle_reg != 2'h3) begin
      settle_reg <= settle_reg + 2'h1;
    end
  end

  function [W-1:0] afsel_default;
    input [2:0] port;
    begin
      case (port)
        `GPE_PORT_B: afsel_default = `GPE_RST_AFSEL_B;
        `GPE_PORT_C: afsel_default = `GPE_RST_AFSEL_C;
        default: afsel_default = `GPE_RST_ZERO;
      endcase
    end
  endfunction

  function [W-1:0] ident_word;
    input [3:0] idx;
    reg [3:0] n;
    begin
      n = idx - `GPE_ID_IDX_BASE;
      if (n < `GPE_ID_WORDS) begin
        ident_word = IDENT_WORDS[n*8 +: 8];
      end else begin
        ident_word = `GPE_RST_ZERO;
      end
    end
  endfunction

  genvar p;
  generate
    for (p = 0; p < NP; p = p + 1) begin : g_port
      localparam [2:0] PIDX = p;
      wire [W-1:0] pin_sync;
      reg [W-1:0] pin_direction_reg;
      reg [W-1:0] alt_function_select_reg;
      reg [W-1:0] pin_value_reg;
      reg [W-1:0] pin_value_next;
      reg [W-1:0] pin_prev_reg;
      reg [W-1:0] irq_sense_select_reg;
      reg [W-1:0] irq_dual_edge_select_reg;
      reg [W-1:0] irq_polarity_select_reg;
      reg [W-1:0] irq_enable_mask_reg;
      reg [W-1:0] edge_latch_reg;
      reg [W-1:0] edge_latch_next;
      reg [W-1:0] drive_low_select_reg;
      reg [W-1:0] drive_mid_select_reg;
      reg [W-1:0] drive_high_select_reg;
      reg [W-1:0] open_drain_select_reg;
      reg [W-1:0] pull_up_select_reg;
      reg [W-1:0] pull_down_select_reg;
      reg [W-1:0] slew_control_select_reg;
      reg [W-1:0] digital_pad_enable_reg;
      reg irq_reg;
      reg [W-1:0] rd_val;
      wire sel = CLK_GATE[p] && (ACC_PORT == PIDX);
      wire wr = sel && ACC_WR;
      wire [W-1:0] rising = pin_sync & ~pin_prev_reg;
      wire [W-1:0] falling = ~pin_sync & pin_prev_reg;
      wire [W-1:0] single_hit = (irq_polarity_select_reg & rising) | (~irq_polarity_select_reg & falling);
      wire [W-1:0] edge_hit = (irq_dual_edge_select_reg & (rising | falling)) |
                              (~irq_dual_edge_select_reg & single_hit);
      wire [W-1:0] level_hit = ~(pin_sync ^ irq_polarity_select_reg);
      wire [W-1:0] irq_raw_flags = (irq_sense_select_reg & level_hit) |
                                   (~irq_sense_select_reg & edge_latch_reg);
      wire [W-1:0] irq_masked_flags = irq_raw_flags & irq_enable_mask_reg;
      wire [W-1:0] irq_flag_clear = (wr && (ACC_ADDR == `GPE_OFS_ICR)) ? ACC_WDATA : `GPE_RST_ZERO;
      wire [W-1:0] eff_oe = (alt_function_select_reg & ALT_OE[p*W +: W]) |
                            (~alt_function_select_reg & pin_direction_reg);
      wire [W-1:0] eff_out = (alt_function_select_reg & ALT_OUT[p*W +: W]) |
                             (~alt_function_select_reg & pin_value_reg);

      // Pins are asynchronous to the system clock
      gpe_sync #(
        .W(W)
      ) u_sync (
        .CLK(CLK),
        .RST_N(RST_N),
        .D(PIN_IN[p*W +: W]),
        .Q(pin_sync)
      );

      always @* begin
        pin_value_next = (pin_direction_reg & pin_value_reg) | (~pin_direction_reg & pin_sync);
        if (wr && in_data_win) begin
          pin_value_next = (pin_value_next & ~addr_mask) | (ACC_WDATA & addr_mask);
        end
        // Set wins over a clear arriving in the same cycle
        edge_latch_next = (edge_latch_reg & ~irq_flag_clear) |
                          (edge_hit & ~irq_sense_select_reg & {W{edge_armed}});
      end

      always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          pin_direction_reg <= `GPE_RST_ZERO;
          alt_function_select_reg <= afsel_default(PIDX);
          pin_value_reg <= `GPE_RST_ZERO;
          pin_prev_reg <= `GPE_RST_ZERO;
          irq_sense_select_reg <= `GPE_RST_ZERO;
          irq_dual_edge_select_reg <= `GPE_RST_ZERO;
          irq_polarity_select_reg <= `GPE_RST_ZERO;
          irq_enable_mask_reg <= `GPE_RST_ZERO;
          edge_latch_reg <= `GPE_RST_ZERO;
          drive_low_select_reg <= `GPE_RST_DR2R;
          drive_mid_select_reg <= `GPE_RST_ZERO;
          drive_high_select_reg <= `GPE_RST_ZERO;
          open_drain_select_reg <= `GPE_RST_ZERO;
          pull_up_select_reg <= `GPE_RST_PUR;
          pull_down_select_reg <= `GPE_RST_ZERO;
          slew_control_select_reg <= `GPE_RST_ZERO;
          digital_pad_enable_reg <= `GPE_RST_DEN;
          irq_reg <= 1'b0;
        end else begin
          pin_value_reg <= pin_value_next;
          pin_prev_reg <= pin_sync;
          edge_latch_reg <= edge_latch_next;
          irq_reg <= |irq_masked_flags;
          if (wr) begin
            case (ACC_ADDR)
              `GPE_OFS_DIR: begin
                pin_direction_reg <= ACC_WDATA;
              end
              `GPE_OFS_IS: begin
                irq_sense_select_reg <= ACC_WDATA;
              end
              `GPE_OFS_IBE: begin
                irq_dual_edge_select_reg <= ACC_WDATA;
              end
              `GPE_OFS_IEV: begin
                irq_polarity_select_reg <= ACC_WDATA;
              end
              `GPE_OFS_IM: begin
                irq_enable_mask_reg <= ACC_WDATA;
              end
              `GPE_OFS_AFSEL: begin
                alt_function_select_reg <= ACC_WDATA;
              end
              `GPE_OFS_DR2R: begin
                drive_low_select_reg <= ACC_WDATA;
              end
              `GPE_OFS_DR4R: begin
                drive_mid_select_reg <= ACC_WDATA;
              end
              `GPE_OFS_DR8R: begin
                drive_high_select_reg <= ACC_WDATA;
              end
              `GPE_OFS_ODR: begin
                open_drain_select_reg <= ACC_WDATA;
              end
              `GPE_OFS_PUR: begin
                pull_up_select_reg <= ACC_WDATA;
              end
              `GPE_OFS_PDR: begin
                pull_down_select_reg <= ACC_WDATA;
              end
              `GPE_OFS_SLR: begin
                slew_control_select_reg <= ACC_WDATA;
              end
              `GPE_OFS_DEN: begin
                digital_pad_enable_reg <= ACC_WDATA;
              end
              default: begin
              end
            endcase
          end
        end
      end

      // Read data is zero unless this port is selected and clocked
      always @* begin
        rd_val = `GPE_RST_ZERO;
        if (sel) begin
          if (in_data_win) begin
            rd_val = pin_value_reg & addr_mask;
          end else if (in_id_win) begin
            rd_val = ident_word(ACC_ADDR[`GPE_ID_IDX_MSB:`GPE_ID_IDX_LSB]);
          end else begin
            case (ACC_ADDR)
              `GPE_OFS_DIR: rd_val = pin_direction_reg;
              `GPE_OFS_IS: rd_val = irq_sense_select_reg;
              `GPE_OFS_IBE: rd_val = irq_dual_edge_select_reg;
              `GPE_OFS_IEV: rd_val = irq_polarity_select_reg;
              `GPE_OFS_IM: rd_val = irq_enable_mask_reg;
              `GPE_OFS_RIS: rd_val = irq_raw_flags;
              `GPE_OFS_MIS: rd_val = irq_masked_flags;
              `GPE_OFS_AFSEL: rd_val = alt_function_select_reg;
              `GPE_OFS_DR2R: rd_val = drive_low_select_reg;
              `GPE_OFS_DR4R: rd_val = drive_mid_select_reg;
              `GPE_OFS_DR8R: rd_val = drive_high_select_reg;
              `GPE_OFS_ODR: rd_val = open_drain_select_reg;
              `GPE_OFS_PUR: rd_val = pull_up_select_reg;
              `GPE_OFS_PDR: rd_val = pull_down_select_reg;
              `GPE_OFS_SLR: rd_val = slew_control_select_reg;
              `GPE_OFS_DEN: rd_val = digital_pad_enable_reg;
              default: rd_val = `GPE_RST_ZERO;
            endcase
          end
        end
      end

      assign rd_all[p*W +: W] = rd_val;
      assign afsel_all[p*W +: W] = alt_function_select_reg;
      // Open-drain pins only ever pull low; a high is left to the pull-up
      assign PIN_OUT[p*W +: W] = eff_out & ~open_drain_select_reg;
      assign PIN_OE[p*W +: W] = eff_oe & (~open_drain_select_reg | ~eff_out);
      assign ALT_IN[p*W +: W] = pin_sync;
      assign PAD_DRV2[p*W +: W] = drive_low_select_reg;
      assign PAD_DRV4[p*W +: W] = drive_mid_select_reg;
      assign PAD_DRV8[p*W +: W] = drive_high_select_reg;
      assign PAD_ODR[p*W +: W] = open_drain_select_reg;
      assign PAD_PU[p*W +: W] = pull_up_select_reg;
      assign PAD_PD[p*W +: W] = pull_down_select_reg;
      assign PAD_SLEW[p*W +: W] = slew_control_select_reg;
      assign PAD_DEN[p*W +: W] = digital_pad_enable_reg;
      assign IRQ[p] = irq_reg;
    end
  endgenerate

  always @* begin
    rd_merge = `GPE_RST_ZERO;
    for (k = 0; k < NP; k = k + 1) begin
      rd_merge = rd_merge | rd_all[k*W +: W];
    end
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ACC_RDATA <= `GPE_RST_ZERO;
      ACC_RVALID <= 1'b0;
    end else begin
      ACC_RVALID <= ACC_RD;
      if (ACC_RD) begin
        ACC_RDATA <= rd_merge;
      end
    end
  end

  // Raw pin feeds the test reset so it works without the system clock running
  assign TEST_RST_N = ~afsel_all[`GPE_TRST_PIN] | PIN_IN[`GPE_TRST_PIN];
endmodule // gpe_top

/* File: gpe_top_asserts.sv */
// Checker on the top-level pins of the five-port I/O block
module gpe_chk #(
  parameter NP = 5,
  parameter [95:0] IDENT_WORDS = 96'h0
) (
  input wire CLK, // Clock
  input wire RST_N, // Reset
  input wire [NP-1:0] CLK_GATE, // Port gates
  input wire [2:0] ACC_PORT, // Port
  input wire [11:0] ACC_ADDR, // Offset
  input wire ACC_WR, // Write
  input wire ACC_RD, // Read
  input wire [7:0] ACC_RDATA, // Read data
  input wire ACC_RVALID, // Answer
  input wire [NP*8-1:0] PIN_IN, // Pads in
  input wire [NP*8-1:0] PIN_OE, // Pad enables
  input wire [NP*8-1:0] ALT_IN, // Synced pins
  input wire [NP*8-1:0] ALT_OE, // Peripheral enables
  input wire [NP*8-1:0] PAD_DRV2, // Low drive
  input wire [NP*8-1:0] PAD_PU, // Pull-ups
  input wire [NP-1:0] IRQ, // Interrupts
  input wire TEST_RST_N // Test reset
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam [NP*8-1:0] AF_RST = 'hF8000;
  logic [1:0] up_cnt_reg;
  wire [7:0] rd_mask = ACC_ADDR[9:2];
  wire rd_ok = ACC_RD && ACC_PORT < 3'h5 && CLK_GATE[ACC_PORT];
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Synchroniser stages are flushed by reset, so their history is trusted only later
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) up_cnt_reg <= 2'h0;
    else if (up_cnt_reg != 2'h3) up_cnt_reg <= up_cnt_reg + 2'h1;
  end
  a_read_answer: assert property (ACC_RD |=> ACC_RVALID)
    else $error("read not answered");
  a_rdata_holds: assert property (!ACC_RVALID |-> $stable(ACC_RDATA))
    else $error("read data moved");
  a_mask_read: assert property (rd_ok && ACC_ADDR[11:10] == 2'h0 |=> (ACC_RDATA & ~$past(rd_mask)) == 8'h00)
    else $error("masked bit read nonzero");
  a_ident_word: assert property (rd_ok && ACC_ADDR == 12'hFD0 |=> ACC_RDATA == IDENT_WORDS[7:0])
    else $error("ident word wrong");
  a_sync_two: assert property (up_cnt_reg == 2'h3 |-> ALT_IN == $past(PIN_IN, 2))
    else $error("sync delay wrong");
  a_reset_state: assert property ($rose(RST_N) |-> PAD_DRV2 == '1 && PAD_PU == '1 && IRQ == '0 && PIN_OE == (ALT_OE & AF_RST))
    else $error("reset state wrong");
  a_trst_pin: assert property ($rose(RST_N) || PIN_IN[15] |-> TEST_RST_N == PIN_IN[15])
    else $error("test reset wrong");
  a_pad_cause: assert property ($changed(PAD_PU) || $changed(PAD_DRV2) |-> $past(ACC_WR))
    else $error("pad setting moved unasked");
  a_gated_zero: assert property (ACC_RD && ACC_PORT < 3'h5 && !CLK_GATE[ACC_PORT] |=> ACC_RDATA == 8'h00)
    else $error("gated port answered");
  c_data_read: cover property (rd_ok && ACC_ADDR[11:10] == 2'h0);
  c_irq_raised: cover property ($rose(IRQ[NP-1]));
  c_gated_read: cover property (ACC_RD && ACC_PORT < 3'h5 && !CLK_GATE[ACC_PORT]);
endmodule // gpe_chk
bind gpe_top gpe_chk #(.NP(NP), .IDENT_WORDS(IDENT_WORDS)) u_gpe_chk (.CLK(CLK), .RST_N(RST_N),
  .CLK_GATE(CLK_GATE), .ACC_PORT(ACC_PORT), .ACC_ADDR(ACC_ADDR), .ACC_WR(ACC_WR), .ACC_RD(ACC_RD),
  .ACC_RDATA(ACC_RDATA), .ACC_RVALID(ACC_RVALID), .PIN_IN(PIN_IN), .PIN_OE(PIN_OE), .ALT_IN(ALT_IN),
  .ALT_OE(ALT_OE), .PAD_DRV2(PAD_DRV2), .PAD_PU(PAD_PU), .IRQ(IRQ), .TEST_RST_N(TEST_RST_N));

/* File: tb_gpe_top.sv */
// Self-checking bench for the five-port I/O block
module tb_gpe_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam [95:0] IDW = 96'h5A4B3C2D_1E0F9786_75645342; // Arbitrary identification values
  logic CLK = 0, RST_N = 0, ACC_WR = 0, ACC_RD = 0, ACC_RVALID, TEST_RST_N;
  logic [4:0] CLK_GATE = 0, IRQ;
  logic [2:0] ACC_PORT = 0;
  logic [11:0] ACC_ADDR = 0;
  logic [7:0] ACC_WDATA = 0, ACC_RDATA, md;
  logic [39:0] PIN_IN, PIN_OUT, PIN_OE, ALT_IN, PAD_DRV2, PAD_PU, PAD_PD, ALT_OUT = 0, ALT_OE = 0, ev = 0;
  logic [39:0] eo = 40'hFFFF000000;
  logic [39:0] PAD_DRV4, PAD_DRV8, PAD_ODR, PAD_SLEW, PAD_DEN;
  logic [7:0] pv [8];
  logic [31:0] seed = 21757, r;
  logic [3:0] modes [4] = '{4'h2, 4'h1, 4'h5, 4'hA};
  logic [3:0] c;
  int num_errors = 0, check_count = 0;
  always #50 CLK = ~CLK;
  gpe_top #(.IDENT_WORDS(IDW)) u_gpe_top (.CLK(CLK), .RST_N(RST_N), .CLK_GATE(CLK_GATE), .ACC_PORT(ACC_PORT),
    .ACC_ADDR(ACC_ADDR), .ACC_WR(ACC_WR), .ACC_RD(ACC_RD), .ACC_WDATA(ACC_WDATA), .ACC_RDATA(ACC_RDATA),
    .ACC_RVALID(ACC_RVALID), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .ALT_IN(ALT_IN),
    .ALT_OUT(ALT_OUT), .ALT_OE(ALT_OE), .PAD_DRV2(PAD_DRV2), .PAD_DRV4(PAD_DRV4), .PAD_DRV8(PAD_DRV8),
    .PAD_ODR(PAD_ODR), .PAD_PU(PAD_PU), .PAD_PD(PAD_PD), .PAD_SLEW(PAD_SLEW), .PAD_DEN(PAD_DEN), .IRQ(IRQ),
    .TEST_RST_N(TEST_RST_N));
  gpe_pin_model u_gpe_pin_model (.clk(CLK), .pin_out(PIN_OUT), .pin_oe(PIN_OE), .pull_up(PAD_PU),
    .pull_down(PAD_PD), .ext_val(ev), .ext_oe(eo), .pin_level(PIN_IN));
  function automatic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic [7:0] mw(input [7:0] old, input [7:0] w, input [7:0] m);
    return (old & ~m) | (w & m);
  endfunction
  task automatic w(input int n);
    repeat (n) @(posedge CLK);
  endtask
  task automatic chk(input [7:0] g, input [7:0] e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t ns: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input [2:0] p, input [11:0] a, input [7:0] d);
    @(posedge CLK);
    ACC_PORT <= p;
    ACC_ADDR <= a;
    ACC_WDATA <= d;
    ACC_WR <= 1'b1;
    @(posedge CLK);
    ACC_WR <= 1'b0;
  endtask
  task automatic rc(input [2:0] p, input [11:0] a, input [7:0] e);
    @(posedge CLK);
    ACC_PORT <= p;
    ACC_ADDR <= a;
    ACC_RD <= 1'b1;
    @(posedge CLK);
    ACC_RD <= 1'b0;
    @(negedge CLK);
    chk({7'h0, ACC_RVALID}, 8'h01);
    chk(ACC_RDATA, e);
  endtask
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge CLK);
    num_errors++;
    stop_test();
  end
  initial begin
    repeat (16) @(posedge CLK);
    RST_N <= 1'b1;
    CLK_GATE <= 5'h1F;
    w(3);
    for (int p = 0; p < 5; p++)
      rc(3'(p), 12'h420, p == 1 ? 8'h80 : p == 2 ? 8'h0F : 8'h00);
    rc(4, 12'h51C, 8'hFF);
    chk(PAD_DEN[39:32], 8'hFF);
    chk(PAD_DRV4[39:32] | PAD_DRV8[39:32] | PAD_ODR[39:32] | PAD_SLEW[39:32], 8'h00);
    wr(0, 12'h400, 8'hFF);
    // Port 0 pins sat pulled high as inputs, so the data register captured ones
    md = mw(8'hFF, 8'hEB, 8'h26);
    wr(0, 12'h098, 8'hEB);
    rc(0, 12'h0C4, md & 8'h31);
    for (int i = 0; i < 24; i++) begin
      r = xs();
      wr(0, {2'b00, r[7:0], r[17:16]}, r[31:24]);
      md = mw(md, r[31:24], r[7:0]);
      @(negedge CLK);
      chk(PIN_OUT[7:0], md);
      rc(0, {2'b00, r[15:8], 2'b00}, md & r[15:8]);
    end
    wr(0, 12'h000, ~md);
    rc(0, 12'h3FC, md);
    for (int j = 0; j < 8; j++) begin
      r = xs();
      pv[j] = r[7:0];
      wr(0, 12'h500 + 12'(4 * j), pv[j]);
      rc(0, 12'h500 + 12'(4 * j), pv[j]);
    end
    chk(PAD_DRV2[7:0], pv[0]);
    chk(PAD_DRV4[7:0], pv[1]);
    chk(PAD_DRV8[7:0], pv[2]);
    chk(PAD_ODR[7:0], pv[3]);
    chk(PAD_PU[7:0], pv[4]);
    chk(PAD_PD[7:0], pv[5]);
    chk(PAD_SLEW[7:0], pv[6]);
    chk(PAD_DEN[7:0], pv[7]);
    // Open-drain pins may only pull low
    chk(PIN_OUT[7:0], md & ~pv[3]);
    chk(PIN_OE[7:0], ~pv[3] | ~md);
    r = xs();
    @(posedge CLK);
    ev[31:24] <= r[7:0];
    w(4);
    rc(3, 12'h3FC, r[7:0]);
    chk(ALT_IN[31:24], r[7:0]);
    wr(3, 12'h420, 8'hFF);
    ALT_OUT[31:24] <= r[15:8];
    ALT_OE[31:24] <= 8'hFF;
    @(negedge CLK);
    chk(PIN_OUT[31:24], r[15:8]);
    chk(PIN_OE[31:24], 8'hFF);
    wr(2, 12'h510, 8'h00);
    @(negedge CLK);
    chk(PAD_PU[23:16], 8'h00);
    for (int n = 0; n < 12; n++)
      rc(2, 12'hFD0 + 12'(4 * n), IDW[8 * n +: 8]);
    wr(2, 12'hFD0, 8'h00);
    rc(2, 12'hFD0, IDW[7:0]);
    rc(2, 12'h600, 8'h00);
    @(posedge CLK);
    CLK_GATE <= 5'h1B;
    rc(2, 12'hFD0, 8'h00);
    @(posedge CLK);
    CLK_GATE <= 5'h1F;
    w(3);
    for (int k = 0; k < 4; k++) begin
      c = modes[k];
      wr(4, 12'h410, 8'h00);
      ev[34] <= c[0];
      wr(4, 12'h404, {5'h0, c[3], 2'h0});
      wr(4, 12'h408, {5'h0, c[2], 2'h0});
      wr(4, 12'h40C, {5'h0, c[1], 2'h0});
      w(4);
      wr(4, 12'h41C, 8'hFF);
      wr(4, 12'h410, 8'h04);
      rc(4, 12'h414, 8'h00);
      @(posedge CLK);
      ev[34] <= ~c[0];
      repeat (6) @(negedge CLK);
      chk({7'h0, IRQ[4]}, 8'h01);
      rc(4, 12'h414, 8'h04);
      rc(4, 12'h418, 8'h04);
      @(posedge CLK);
      ev[34] <= c[0];
      w(5);
      rc(4, 12'h414, c[3] ? 8'h00 : 8'h04);
      wr(4, 12'h41C, 8'h04);
      rc(4, 12'h414, 8'h00);
      chk({7'h0, IRQ[4]}, 8'h00);
    end
    wr(4, 12'h410, 8'h00);
    wr(4, 12'h404, 8'h00);
    wr(4, 12'h41C, 8'hFF);
    ev[34] <= 1'b1;
    w(5);
    rc(4, 12'h414, 8'h04);
    rc(4, 12'h418, 8'h00);
    chk({7'h0, IRQ[4]}, 8'h00);
    wr(4, 12'h41C, 8'h00);
    rc(4, 12'h414, 8'h04);
    wr(1, 12'h420, 8'h00);
    eo[15] <= 1'b1;
    @(negedge CLK);
    chk({7'h0, TEST_RST_N}, 8'h01);
    @(posedge CLK);
    RST_N <= 1'b0;
    @(negedge CLK);
    chk({7'h0, TEST_RST_N}, 8'h00);
    @(posedge CLK);
    RST_N <= 1'b1;
    rc(1, 12'h420, 8'h80);
    rc(0, 12'h400, 8'h00);
    chk(PIN_OE[7:0], 8'h00);
    stop_test();
  end
endmodule // tb_gpe_top
